/* hw/dbg_link_pkg.sv */
// Constants for the debug link access register bank
package dbg_link_pkg;
	localparam logic [3:0] OFS_PHY_DIS    = 4'h3;
	localparam logic [3:0] OFS_KEY_STAT   = 4'h7;
	localparam logic [3:0] OFS_RST_REQ    = 4'h8;
	localparam logic [3:0] OFS_CLK_SEL    = 4'h9;
	localparam logic [3:0] OFS_SYS_CTRL   = 4'hA;
	localparam logic [3:0] OFS_SYS_STAT   = 4'hB;
	localparam logic [3:0] OFS_CRC_STAT   = 4'hC;
	localparam int BIT_NACK_DIS    = 4;
	localparam int BIT_COLL_DIS    = 3;
	localparam int BIT_LINK_DIS    = 2;
	localparam int BIT_KEY_UROW    = 5;
	localparam int BIT_KEY_NVM     = 4;
	localparam int BIT_KEY_ERASE   = 3;
	localparam int BIT_RST_HELD    = 0;
	localparam int BIT_UROW_DONE   = 1;
	localparam int BIT_CLK_REQ     = 0;
	localparam int BIT_RST_ACTIVE  = 5;
	localparam int BIT_SLEEPING    = 4;
	localparam int BIT_NVM_READY   = 3;
	localparam int BIT_UROW_READY  = 2;
	localparam int BIT_LOCKED      = 0;
	localparam logic [7:0] RESET_SIGNATURE = 8'h59;
	localparam logic [1:0] CLK_SEL_16M     = 2'h1;
	localparam logic [1:0] CLK_SEL_8M      = 2'h2;
	localparam logic [1:0] CLK_SEL_4M      = 2'h3;
	localparam logic [1:0] CLK_SEL_RESET   = 2'h3;
	localparam logic [7:0] CRC_OFF         = 8'h00;
	localparam logic [7:0] CRC_BUSY        = 8'h01;
	localparam logic [7:0] CRC_PASS        = 8'h02;
	localparam logic [7:0] CRC_FAIL        = 8'h04;
	localparam logic [7:0] PHY_DIS_RESET   = 8'h00;
	typedef enum logic [1:0] {CRC_ST_OFF, CRC_ST_BUSY, CRC_ST_PASS, CRC_ST_FAIL} crc_state_t;
endpackage : dbg_link_pkg

/* hw/key_tracker.sv */
// Key status flags; nvm and erase keys clear automatically on sequence completion
`timescale 1ns/1ps
module key_tracker (
	// Clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_rstn,
	// Key events
	input  wire logic       i_clear_all,
	input  wire logic [2:0] i_key_set,
	input  wire logic       i_nvm_done,
	input  wire logic       i_erase_done,
	// Key state: {user_row, nvm, erase}
	output logic      [2:0] o_keys
);
	logic [2:0] keys_ff;
	logic [2:0] nxt_keys;

	always_comb begin
		nxt_keys = keys_ff | i_key_set;
		if (i_nvm_done) begin
			nxt_keys[1] = 1'b0; // RULE5
		end
		if (i_erase_done) begin
			nxt_keys[0] = 1'b0; // RULE6
		end
		if (i_clear_all) begin
			nxt_keys = 3'h0; // RULE3
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			keys_ff <= 3'h0;
		end else begin
			keys_ff <= nxt_keys;
		end
	end

	assign o_keys = keys_ff;

	a_nvm_autoclear: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		i_nvm_done |=> !keys_ff[1]) else $error("nvm key not cleared"); // RULE5
	a_erase_autoclear: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		i_erase_done |=> !keys_ff[0]) else $error("erase key not cleared"); // RULE6
endmodule : key_tracker

/* hw/crc_status_track.sv */
// One-hot CRC run status tracker
`timescale 1ns/1ps
module crc_status_track
	import dbg_link_pkg::*;
(
	// Clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_rstn,
	// CRC engine events
	input  wire logic       i_crc_enable,
	input  wire logic       i_crc_done,
	input  wire logic       i_crc_ok,
	// Encoded status
	output logic      [7:0] o_status
);
	crc_state_t st_ff;
	crc_state_t nxt_st;
	logic [7:0] stat_ff;
	logic [7:0] nxt_stat;

	always_comb begin
		nxt_st = st_ff;
		if (!i_crc_enable) begin
			nxt_st = CRC_ST_OFF;
		end else if (i_crc_done) begin
			nxt_st = i_crc_ok ? CRC_ST_PASS : CRC_ST_FAIL;
		end else if (st_ff == CRC_ST_OFF) begin
			nxt_st = CRC_ST_BUSY;
		end
		case (nxt_st)
			CRC_ST_BUSY: nxt_stat = CRC_BUSY; // RULE21
			CRC_ST_PASS: nxt_stat = CRC_PASS;
			CRC_ST_FAIL: nxt_stat = CRC_FAIL;
			default:     nxt_stat = CRC_OFF;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			st_ff   <= CRC_ST_OFF;
			stat_ff <= CRC_OFF;
		end else begin
			st_ff   <= nxt_st;
			stat_ff <= nxt_stat;
		end
	end

	assign o_status = stat_ff;

	a_crc_onehot: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		$onehot0(stat_ff) && stat_ff[7:3] == 5'h00) else $error("crc status not one-hot"); // RULE21
endmodule : crc_status_track

/* hw/dbg_link_regs.sv */
// Register bank of the debug link access system interface
`timescale 1ns/1ps
// Function
// [RULE1] Neg-ack disable suppresses neg-ack on reset
// [RULE2] Collision disable stops contention detection
// [RULE3] Link disable drops clock request, clears keys
// [RULE4] Key status bits mirror active keys
// [RULE5] Memory program key clears when done
// [RULE6] Chip erase key clears when done
// [RULE7] Writing 0x59 holds system reset
// [RULE8] Any other value releases system reset
// [RULE9] Reset request reads bit0 held state
// [RULE10] System reset leaves link logic running
// [RULE11] Clock select: 1=16,2=8,3=4 MHz
// [RULE12] Debugger keeps 4 MHz unless high brown-out
// [RULE13] User-row done needs key, starts programming
// [RULE14] Debugger writes data before user-row done
// [RULE15] Clock request bit keeps system clock
// [RULE16] Reset-active status sticky, clears on read
// [RULE17] Sleeping status follows system sleep
// [RULE18] Memory-program ready; debugger resets after
// [RULE19] User-row ready; debugger writes done after
// [RULE20] Lock status shows device locked
// [RULE21] CRC status is one-hot encoded
// [RULE22] Registers reachable only through debug link
// [RULE23] Reserved bits read zero, ignore writes
module dbg_link_regs (
	// Clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_rstn,
	// Debug link register access port
	input  wire logic [3:0] i_reg_addr,
	input  wire logic [7:0] i_reg_wdata,
	input  wire logic       i_reg_wr,
	input  wire logic       i_reg_rd,
	output logic      [7:0] o_reg_rdata,
	// Link enable and key decode
	input  wire logic       i_link_enable,
	input  wire logic [2:0] i_key_decoded,
	// System state
	input  wire logic       i_sys_in_reset,
	input  wire logic       i_sys_sleeping,
	input  wire logic       i_nvm_prog_ready,
	input  wire logic       i_urow_prog_ready,
	input  wire logic       i_nvm_done,
	input  wire logic       i_erase_done,
	input  wire logic       i_device_locked,
	// CRC engine
	input  wire logic       i_crc_enable,
	input  wire logic       i_crc_done,
	input  wire logic       i_crc_ok,
	// Controls to physical layer and system
	output logic            o_neg_ack_disable,
	output logic            o_collision_detect_disable,
	output logic            o_link_phy_on,
	output logic            o_link_clk_request,
	output logic      [1:0] o_link_clock_choice,
	output logic            o_system_reset,
	output logic            o_system_clock_request,
	output logic            o_user_row_program_start
);
	import dbg_link_pkg::*;

	logic       nack_dis_ff, nxt_nack_dis;
	logic       coll_dis_ff, nxt_coll_dis;
	logic       link_off_ff, nxt_link_off;
	logic       rst_hold_ff, nxt_rst_hold;
	logic [1:0] clk_sel_ff, nxt_clk_sel;
	logic       clk_req_ff, nxt_clk_req;
	logic       urow_go_ff, nxt_urow_go;
	logic       rst_seen_ff, nxt_rst_seen;
	logic       enable_d_ff;
	logic       phy_on_ff, nxt_phy_on;
	logic [7:0] rdata_ff, nxt_rdata;
	logic [2:0] keys;
	logic [7:0] crc_stat;
	logic       clear_all;
	logic       wr_phy, wr_rst, wr_clk, wr_sys, rd_sys;
	logic       link_rise;

	// Link disable or enable edge wipes physical configuration and keys
	assign link_rise = i_link_enable && !enable_d_ff;
	assign clear_all = !i_link_enable || link_rise || (wr_phy && i_reg_wdata[BIT_LINK_DIS]); // RULE3
	assign wr_phy = i_reg_wr && i_reg_addr == OFS_PHY_DIS;
	assign wr_rst = i_reg_wr && i_reg_addr == OFS_RST_REQ;
	assign wr_clk = i_reg_wr && i_reg_addr == OFS_CLK_SEL;
	assign wr_sys = i_reg_wr && i_reg_addr == OFS_SYS_CTRL;
	assign rd_sys = i_reg_rd && i_reg_addr == OFS_SYS_STAT;

	key_tracker u_keys (
		.i_ref_clk    (i_ref_clk),
		.i_rstn       (i_rstn),
		.i_clear_all  (clear_all),
		.i_key_set    (i_key_decoded),
		.i_nvm_done   (i_nvm_done),
		.i_erase_done (i_erase_done),
		.o_keys       (keys)
	);

	crc_status_track u_crc (
		.i_ref_clk    (i_ref_clk),
		.i_rstn       (i_rstn),
		.i_crc_enable (i_crc_enable),
		.i_crc_done   (i_crc_done),
		.i_crc_ok     (i_crc_ok),
		.o_status     (crc_stat)
	);

	// Control register next state
	always_comb begin
		nxt_nack_dis = nack_dis_ff;
		nxt_coll_dis = coll_dis_ff;
		nxt_link_off = link_off_ff;
		nxt_rst_hold = rst_hold_ff;
		nxt_clk_sel  = clk_sel_ff;
		nxt_clk_req  = clk_req_ff;
		nxt_urow_go  = 1'b0;
		if (wr_phy) begin
			nxt_nack_dis = i_reg_wdata[BIT_NACK_DIS]; // RULE1
			nxt_coll_dis = i_reg_wdata[BIT_COLL_DIS]; // RULE2
			nxt_link_off = i_reg_wdata[BIT_LINK_DIS]; // RULE3
		end
		if (wr_rst) begin
			nxt_rst_hold = (i_reg_wdata == RESET_SIGNATURE); // RULE7 RULE8
		end
		if (wr_clk && i_reg_wdata[1:0] != 2'h0) begin
			nxt_clk_sel = i_reg_wdata[1:0]; // RULE11
		end
		if (wr_sys) begin
			nxt_clk_req = i_reg_wdata[BIT_CLK_REQ]; // RULE15
			nxt_urow_go = i_reg_wdata[BIT_UROW_DONE] && keys[2]; // RULE13
		end
		if (clear_all) begin
			nxt_nack_dis = 1'b0; // RULE3
			nxt_coll_dis = 1'b0;
			nxt_clk_sel  = CLK_SEL_RESET; // RULE11
			nxt_clk_req  = link_rise; // RULE15
			nxt_urow_go  = 1'b0;
			nxt_link_off = !i_link_enable || (wr_phy && i_reg_wdata[BIT_LINK_DIS]);
		end
		nxt_phy_on = !nxt_link_off; // RULE3
	end

	// Sticky reset-active flag; a new reset wins over the read clear
	always_comb begin
		nxt_rst_seen = rst_seen_ff;
		if (rd_sys) begin
			nxt_rst_seen = 1'b0; // RULE16
		end
		if (i_sys_in_reset || rst_hold_ff) begin
			nxt_rst_seen = 1'b1; // RULE16
		end
	end

	// Read mux; only the link port reaches these registers
	always_comb begin
		nxt_rdata = 8'h00; // RULE22 RULE23
		if (i_reg_rd) begin
			case (i_reg_addr)
				OFS_PHY_DIS: begin
					nxt_rdata[BIT_NACK_DIS] = nack_dis_ff;
					nxt_rdata[BIT_COLL_DIS] = coll_dis_ff;
					nxt_rdata[BIT_LINK_DIS] = link_off_ff;
				end
				OFS_KEY_STAT: begin
					nxt_rdata[BIT_KEY_UROW]  = keys[2]; // RULE4
					nxt_rdata[BIT_KEY_NVM]   = keys[1];
					nxt_rdata[BIT_KEY_ERASE] = keys[0];
				end
				OFS_RST_REQ: begin
					nxt_rdata[BIT_RST_HELD] = rst_hold_ff; // RULE9
				end
				OFS_CLK_SEL: begin
					nxt_rdata[1:0] = clk_sel_ff;
				end
				OFS_SYS_CTRL: begin
					nxt_rdata[BIT_CLK_REQ] = clk_req_ff;
				end
				OFS_SYS_STAT: begin
					nxt_rdata[BIT_RST_ACTIVE] = rst_seen_ff || i_sys_in_reset || rst_hold_ff; // RULE16
					nxt_rdata[BIT_SLEEPING]   = i_sys_sleeping; // RULE17
					nxt_rdata[BIT_NVM_READY]  = i_nvm_prog_ready; // RULE18
					nxt_rdata[BIT_UROW_READY] = i_urow_prog_ready; // RULE19
					nxt_rdata[BIT_LOCKED]     = i_device_locked; // RULE20
				end
				OFS_CRC_STAT: begin
					nxt_rdata = crc_stat; // RULE21
				end
				default: begin
					nxt_rdata = 8'h00;
				end
			endcase
		end
	end

	// Only the link reset clears this state; the issued system reset does not
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin // RULE10
			nack_dis_ff <= 1'b0;
			coll_dis_ff <= 1'b0;
			link_off_ff <= 1'b0;
			rst_hold_ff <= 1'b0;
			clk_sel_ff  <= CLK_SEL_RESET;
			clk_req_ff  <= 1'b0;
			urow_go_ff  <= 1'b0;
			rst_seen_ff <= 1'b0;
			enable_d_ff <= 1'b0;
			phy_on_ff   <= 1'b1;
			rdata_ff    <= 8'h00;
		end else begin
			nack_dis_ff <= nxt_nack_dis;
			coll_dis_ff <= nxt_coll_dis;
			link_off_ff <= nxt_link_off;
			rst_hold_ff <= nxt_rst_hold;
			clk_sel_ff  <= nxt_clk_sel;
			clk_req_ff  <= nxt_clk_req;
			urow_go_ff  <= nxt_urow_go;
			rst_seen_ff <= nxt_rst_seen;
			enable_d_ff <= i_link_enable;
			phy_on_ff   <= nxt_phy_on;
			rdata_ff    <= nxt_rdata;
		end
	end

	assign o_reg_rdata                = rdata_ff;
	assign o_neg_ack_disable          = nack_dis_ff; // RULE1
	assign o_collision_detect_disable = coll_dis_ff; // RULE2
	assign o_link_phy_on              = phy_on_ff; // RULE3
	assign o_link_clk_request         = phy_on_ff;
	assign o_link_clock_choice        = clk_sel_ff;
	assign o_system_reset             = rst_hold_ff; // RULE7
	assign o_system_clock_request     = clk_req_ff; // RULE15
	assign o_user_row_program_start   = urow_go_ff; // RULE13

	a_rst_sig_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		wr_rst && i_reg_wdata == RESET_SIGNATURE |=> o_system_reset) else $error("signature did not hold reset"); // RULE7
	a_rst_release: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		wr_rst && i_reg_wdata != RESET_SIGNATURE |=> !o_system_reset) else $error("reset not released"); // RULE8
	a_rst_readback: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		i_reg_rd && i_reg_addr == OFS_RST_REQ |=> o_reg_rdata == {7'h00, $past(rst_hold_ff)})
		else $error("reset request readback wrong"); // RULE9
	a_link_dis_clr: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		wr_phy && i_reg_wdata[BIT_LINK_DIS] |=> !o_link_clk_request && keys == 3'h0 && !o_system_clock_request)
		else $error("link disable did not clear"); // RULE3
	a_urow_gated: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		o_user_row_program_start |-> $past(keys[2]) && $past(wr_sys)) else $error("user row start without key"); // RULE13
	a_clk_sel_legal: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		o_link_clock_choice != 2'h0) else $error("reserved clock select"); // RULE11
	a_rst_seen_sticky: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		o_system_reset ##1 (i_reg_rd && i_reg_addr == OFS_SYS_STAT) |=> o_reg_rdata[BIT_RST_ACTIVE])
		else $error("reset active not reported"); // RULE16
	a_key_readback: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		i_reg_rd && i_reg_addr == OFS_KEY_STAT |=> o_reg_rdata == {2'h0, $past(keys), 3'h0})
		else $error("key status readback wrong"); // RULE4
	c_reset_cycle: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
		o_system_reset ##[1:20] !o_system_reset);
	c_urow_start: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) o_user_row_program_start);
	c_link_off: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) !o_link_phy_on);
	c_clk_fast: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) o_link_clock_choice == CLK_SEL_16M);
	c_crc_read: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
		i_reg_rd && i_reg_addr == OFS_CRC_STAT);

	a_nack_follow: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		wr_phy && !clear_all |=> o_neg_ack_disable == $past(i_reg_wdata[BIT_NACK_DIS]))
		else $error("neg-ack disable not written"); // RULE1
	a_coll_follow: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		wr_phy && !clear_all |=> o_collision_detect_disable == $past(i_reg_wdata[BIT_COLL_DIS]))
		else $error("collision disable not written"); // RULE2
	a_sleep_readback: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		rd_sys |=> o_reg_rdata[BIT_SLEEPING] == $past(i_sys_sleeping))
		else $error("sleeping status readback wrong"); // RULE17
	a_lock_readback: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		rd_sys |=> o_reg_rdata[BIT_LOCKED] == $past(i_device_locked))
		else $error("lock status readback wrong"); // RULE20
	a_stat_rsvd_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		rd_sys |=> o_reg_rdata[7:6] == 2'h0 && !o_reg_rdata[1])
		else $error("reserved status bits not zero"); // RULE23
	a_clk_sel_keep: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		wr_clk && i_reg_wdata[1:0] == 2'h0 && !clear_all |=> $stable(o_link_clock_choice))
		else $error("reserved clock select taken"); // RULE11
	a_clk_req_write: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		wr_sys && !clear_all |=> o_system_clock_request == $past(i_reg_wdata[BIT_CLK_REQ]))
		else $error("clock request not written"); // RULE15
	a_idle_rdata_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		!i_reg_rd |=> o_reg_rdata == 8'h00)
		else $error("read data not zero when idle"); // RULE23
endmodule : dbg_link_regs

/* tb/sys_domain_model.sv */
// System domain model facing the debug link register bank
`timescale 1ns/1ps
module sys_domain_model (
	// Clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_rstn,
	// Requests from the register bank and bench
	input  wire logic i_hold_reset,
	input  wire logic i_erase_done,
	input  wire logic i_sleep_cmd,
	// System state seen by the register bank
	output logic      o_sys_in_reset,
	output logic      o_sys_sleeping,
	output logic      o_device_locked
);
	logic locked_ff;
	logic nxt_locked;
	always_comb begin
		nxt_locked = locked_ff & ~i_erase_done;
	end
	always_ff @(posedge i_ref_clk) begin
		locked_ff <= i_rstn ? nxt_locked : 1'b1;
	end
	// Held reset puts the domain, all but its lock flag, in reset, which also ends sleep
	assign o_sys_in_reset  = i_hold_reset;
	assign o_sys_sleeping  = i_sleep_cmd & ~i_hold_reset;
	assign o_device_locked = locked_ff;
endmodule : sys_domain_model

/* tb/dbg_link_regs_tb.sv */
// Self-checking bench for the debug link register bank
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module dbg_link_regs_tb;
	import dbg_link_pkg::*;
	logic       clk, rstn, wr, rd, link_en, nvm_rdy, urow_rdy, nvm_done, erase_done;
	logic       sleep_cmd, crc_en, crc_done, crc_ok, nack, coll, phy_on, lclk_req;
	logic       sys_rst, sclk_req, urow_start, in_rst, sleeping, locked;
	logic [3:0] addr;
	logic [7:0] wdata, rdata;
	logic [2:0] key_dec;
	logic [1:0] clk_choice;
	logic [1:0] sels [3];
	int         mismatches = 0;
	int         checks = 0;
	int         cycles = 0;
	always #25 clk = ~clk;
	dbg_link_regs DUT (.i_ref_clk(clk), .i_rstn(rstn), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_link_enable(link_en),
		.i_key_decoded(key_dec), .i_sys_in_reset(in_rst), .i_sys_sleeping(sleeping),
		.i_nvm_prog_ready(nvm_rdy), .i_urow_prog_ready(urow_rdy), .i_nvm_done(nvm_done),
		.i_erase_done(erase_done), .i_device_locked(locked), .i_crc_enable(crc_en),
		.i_crc_done(crc_done), .i_crc_ok(crc_ok), .o_neg_ack_disable(nack),
		.o_collision_detect_disable(coll), .o_link_phy_on(phy_on), .o_link_clk_request(lclk_req),
		.o_link_clock_choice(clk_choice), .o_system_reset(sys_rst),
		.o_system_clock_request(sclk_req), .o_user_row_program_start(urow_start));
	sys_domain_model partner (.i_ref_clk(clk), .i_rstn(rstn), .i_hold_reset(sys_rst),
		.i_erase_done(erase_done), .i_sleep_cmd(sleep_cmd), .o_sys_in_reset(in_rst),
		.o_sys_sleeping(sleeping), .o_device_locked(locked));
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		`CHK(rdata, e)
	endtask : rd_chk
	// Pulses {key_dec, nvm_done, erase_done, crc_done} for one cycle
	task automatic ev(input logic [5:0] p);
		@(negedge clk);
		{key_dec, nvm_done, erase_done, crc_done} = p;
		@(negedge clk);
		{key_dec, nvm_done, erase_done, crc_done} = 6'h00;
	endtask : ev
	task automatic endt(input string n);
		$display("test %s done", n);
	endtask : endt
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	initial begin
		{clk, rstn, wr, rd, link_en, nvm_rdy, urow_rdy, nvm_done, erase_done} = 9'h000;
		{sleep_cmd, crc_en, crc_done, crc_ok, key_dec} = 7'h00;
		addr = 4'h0;
		wdata = 8'h00;
		sels = '{CLK_SEL_16M, CLK_SEL_8M, CLK_SEL_4M};
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		link_en = 1'b1;
		repeat (2) @(negedge clk);
		`CHK(phy_on, 1'b1)
		`CHK(sclk_req, 1'b1)
		`CHK(clk_choice, CLK_SEL_RESET)
		rd_chk(OFS_PHY_DIS, PHY_DIS_RESET);
		rd_chk(OFS_KEY_STAT, 8'h00);
		rd_chk(OFS_RST_REQ, 8'h00);
		rd_chk(OFS_CLK_SEL, 8'h03);
		rd_chk(OFS_SYS_CTRL, 8'h01);
		rd_chk(OFS_SYS_STAT, 8'h01);
		rd_chk(OFS_CRC_STAT, CRC_OFF);
		rd_chk(4'h5, 8'h00);
		endt("reset_values");
		wr_reg(OFS_PHY_DIS, 8'h18);
		`CHK(nack, 1'b1)
		`CHK(coll, 1'b1)
		rd_chk(OFS_PHY_DIS, 8'h18);
		wr_reg(OFS_PHY_DIS, 8'hE3);
		`CHK(nack, 1'b0)
		`CHK(coll, 1'b0)
		rd_chk(OFS_PHY_DIS, 8'h00);
		ev(6'b111000);
		rd_chk(OFS_KEY_STAT, 8'h38);
		wr_reg(OFS_PHY_DIS, 8'h04);
		`CHK({phy_on, lclk_req}, 2'b00)
		`CHK(sclk_req, 1'b0)
		rd_chk(OFS_KEY_STAT, 8'h00);
		wr_reg(OFS_PHY_DIS, 8'h00);
		`CHK(phy_on, 1'b1)
		wr_reg(OFS_SYS_CTRL, 8'h01);
		`CHK(sclk_req, 1'b1)
		wr_reg(OFS_SYS_CTRL, 8'h00);
		`CHK(sclk_req, 1'b0)
		endt("phy_disable");
		wr_reg(OFS_SYS_CTRL, 8'h02);
		`CHK(urow_start, 1'b0)
		ev(6'b111000);
		ev(6'b000100);
		rd_chk(OFS_KEY_STAT, 8'h28);
		ev(6'b000010);
		rd_chk(OFS_KEY_STAT, 8'h20);
		rd_chk(OFS_SYS_STAT, 8'h00);
		// User row data is in place before the done bit is written
		wr_reg(OFS_SYS_CTRL, 8'h02);
		`CHK(urow_start, 1'b1)
		@(negedge clk);
		`CHK(urow_start, 1'b0)
		endt("keys");
		{sleep_cmd, nvm_rdy, urow_rdy} = 3'b111;
		rd_chk(OFS_SYS_STAT, 8'h1C);
		wr_reg(OFS_RST_REQ, RESET_SIGNATURE);
		`CHK(sys_rst, 1'b1)
		rd_chk(OFS_RST_REQ, 8'h01);
		rd_chk(OFS_SYS_STAT, 8'h2C);
		wr_reg(OFS_CLK_SEL, {6'h00, CLK_SEL_16M});
		`CHK(clk_choice, CLK_SEL_16M)
		wr_reg(OFS_RST_REQ, 8'h58);
		`CHK(sys_rst, 1'b0)
		rd_chk(OFS_RST_REQ, 8'h00);
		{sleep_cmd, nvm_rdy, urow_rdy} = 3'b000;
		rd_chk(OFS_SYS_STAT, 8'h20);
		rd_chk(OFS_SYS_STAT, 8'h00);
		endt("system_reset");
		// Faster link clocks assume the brown-out level is at its highest
		for (int i = 0; i < 3; i++) begin
			wr_reg(OFS_CLK_SEL, {6'h00, sels[i]});
			`CHK(clk_choice, sels[i])
			rd_chk(OFS_CLK_SEL, {6'h00, sels[i]});
		end
		wr_reg(OFS_CLK_SEL, 8'hFC);
		`CHK(clk_choice, CLK_SEL_4M)
		rd_chk(OFS_CLK_SEL, 8'h03);
		endt("clock_select");
		crc_en = 1'b1;
		rd_chk(OFS_CRC_STAT, CRC_BUSY);
		crc_ok = 1'b1;
		ev(6'b000001);
		rd_chk(OFS_CRC_STAT, CRC_PASS);
		wr_reg(OFS_CRC_STAT, 8'hFF);
		rd_chk(OFS_CRC_STAT, CRC_PASS);
		crc_en = 1'b0;
		rd_chk(OFS_CRC_STAT, CRC_OFF);
		crc_en = 1'b1;
		crc_ok = 1'b0;
		ev(6'b000001);
		rd_chk(OFS_CRC_STAT, CRC_FAIL);
		endt("crc_status");
		tally_and_finish();
	end
endmodule : dbg_link_regs_tb
